// File: core/ivm_top.v
// Interrupt vector mapper: source mapping, pending state, nesting, vector fetch
`timescale 1ns/1ns
`include "ivm_defs.vh"

module ivm_top #(
  parameter NIRQ  = `IVM_NUM_IRQ,  // Maskable peripheral channels
  parameter DEPTH = 18             // Nesting stack depth (one fewer than the 19 level codes)
) (
  // Clock and reset
  input  wire                    mclk_i,
  input  wire                    rst_i,
  // Dedicated peripheral requests, one per vector number
  input  wire [NIRQ-1:0]         periph_irq_i,
  // Named sources that are mapped or merged here
  input  wire [`IVM_N_EXT-1:0]   ext_line_irq_i,
  input  wire [`IVM_N_DMA_A-1:0] dma_a_channel_irq_i,
  input  wire                    usb_hipri_irq_i,
  input  wire                    can_a_tx_irq_i,
  input  wire                    usb_lopri_irq_i,
  input  wire                    can_a_rx0_irq_i,
  input  wire                    can_a_rx1_irq_i,
  input  wire                    adc_a_irq_i,
  input  wire                    adc_b_irq_i,
  input  wire                    tamper_irq_i,
  input  wire [`IVM_N_TMR_A-1:0] adv_timer_a_irq_i,
  input  wire [`IVM_N_TMR_B-1:0] adv_timer_b_irq_i,
  // Core fixed exceptions
  input  wire                    nmi_i,
  input  wire                    hard_fault_i,
  // Configuration from core-side logic
  input  wire [NIRQ-1:0]         irq_enable_i,
  input  wire [NIRQ*`IVM_PRIO_W-1:0] irq_prio_i,
  // Core exception entry handshake
  input  wire                    exc_ack_i,
  input  wire                    exc_return_i,
  output reg                     exc_req_o,
  output reg  [`IVM_EXC_W-1:0]   exc_num_o,
  output reg  [31:0]             exc_vec_addr_o,
  output reg  [`IVM_LVL_W-1:0]   exc_level_o,
  // Status
  output reg  [NIRQ-1:0]         pending_o,
  output reg  [`IVM_LVL_W-1:0]   active_level_o
);

  // Three-stage pin synchroniser state
  reg  [`IVM_N_EXT-1:0]  ext_s1;         // First stage, read only by stage two
  reg  [`IVM_N_EXT-1:0]  ext_s2;         // Second stage
  reg  [`IVM_N_EXT-1:0]  ext_s3;         // Third stage
  reg  [`IVM_N_EXT-1:0]  ext_lvl;        // Accepted line level

  // Fixed exception pending state
  reg                    rst_pend;       // Reset entry still owed
  reg                    nmi_pend;       // NMI waiting
  reg                    nmi_prev;       // NMI input last cycle

  // Nesting stack of active level codes
  reg  [`IVM_LVL_W-1:0]  stk [0:DEPTH-1];
  reg  [4:0]             sp;             // Entries in use

  // Mapped requests and arbiter result
  reg  [NIRQ-1:0]        req_map;        // Per-vector raw request
  wire                   arb_valid;      // Some enabled channel pending
  wire [`IVM_EXC_W-1:0]  arb_idx;        // Winning vector number
  wire [`IVM_LVL_W-1:0]  arb_lvl;        // Winning level code
  reg                    next_req;       // Candidate worth presenting
  reg  [`IVM_EXC_W-1:0]  next_num;       // Candidate exception number
  reg  [`IVM_LVL_W-1:0]  next_lvl;       // Candidate level code
  wire [`IVM_LVL_W-1:0]  top_lvl;        // Level now running
  wire                   taken;          // Entry accepted this cycle
  integer                k;              // Source walk, mapping only
  integer                j;              // Stack walk, reset only

  // Exception number to table byte address
  // table entry fetch
  function [31:0] vec_addr;
    input [`IVM_EXC_W-1:0] num;
    begin
      vec_addr = {{(32-`IVM_EXC_W){1'b0}}, num} << `IVM_VT_SHIFT;
    end
  endfunction

  // Pin lines: a change is accepted only once stages two and three agree
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_s1  <= {`IVM_N_EXT{1'b0}};
      ext_s2  <= {`IVM_N_EXT{1'b0}};
      ext_s3  <= {`IVM_N_EXT{1'b0}};
      ext_lvl <= {`IVM_N_EXT{1'b0}};
    end
    else
    begin
      ext_s1  <= ext_line_irq_i;
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
      ext_lvl <= (ext_s2 & ext_s3) | (ext_lvl & (ext_s2 | ext_s3));
    end
  end

  // Route every source onto its vector number; named sources override the
  // generic bus so a peripheral cannot double-drive a shared slot
  always @*
  begin
    req_map = periph_irq_i;
    req_map[`IVM_VEC_TAMPER] = tamper_irq_i;
    for (k = 0; k < `IVM_N_EXT_OWN; k = k + 1)
      req_map[`IVM_VEC_EXT0 + k] = ext_lvl[k];
    for (k = 0; k < `IVM_N_DMA_A; k = k + 1)
      req_map[`IVM_VEC_DMA_A + k] = dma_a_channel_irq_i[k];
    req_map[`IVM_VEC_ADC] = adc_a_irq_i | adc_b_irq_i;
    req_map[`IVM_VEC_USB_HI] = usb_hipri_irq_i | can_a_tx_irq_i;
    req_map[`IVM_VEC_USB_LO] = usb_lopri_irq_i | can_a_rx0_irq_i;
    req_map[`IVM_VEC_CAN_RX1] = can_a_rx1_irq_i;
    req_map[`IVM_VEC_EXT5_9] = |ext_lvl[`IVM_EXT_MID_HI:`IVM_N_EXT_OWN];
    for (k = 0; k < `IVM_N_TMR_A; k = k + 1)
      req_map[`IVM_VEC_TMR_A + k] = adv_timer_a_irq_i[k];
    req_map[`IVM_VEC_EXT10_15] = |ext_lvl[`IVM_N_EXT-1:`IVM_EXT_HI_LO];
    for (k = 0; k < `IVM_N_TMR_B; k = k + 1)
      req_map[`IVM_VEC_TMR_B + k] = adv_timer_b_irq_i[k];
  end

  // one arbiter over all maskable channels
  ivm_prio_arb #(
    .N       (NIRQ)
  ) u_arb (
    .req_i   (pending_o & irq_enable_i),
    .prio_i  (irq_prio_i),
    .valid_o (arb_valid),
    .idx_o   (arb_idx),
    .lvl_o   (arb_lvl)
  );

  // Running level is the stack top, idle when nothing is active
  assign top_lvl        = (sp == 5'h00) ? `IVM_LVL_IDLE : stk[sp - 5'h01];
  assign taken          = exc_req_o & exc_ack_i;

  // Registered copy of the running level for status; it trails a push or
  // pop by one cycle, which is harmless since an offer needs that cycle too
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      active_level_o <= `IVM_LVL_IDLE;
    else
      active_level_o <= top_lvl;
  end

  // Candidate choice; fixed exceptions come first in a set order
  // fixed priority order
  always @*
  begin
    next_req = 1'b0;
    next_num = {`IVM_EXC_W{1'b0}};
    next_lvl = `IVM_LVL_IDLE;
    if (rst_pend)
    begin
      next_num = `IVM_EXC_RESET;
      next_lvl = `IVM_LVL_RESET;
    end
    else if (nmi_pend)
    begin
      next_num = `IVM_EXC_NMI;
      next_lvl = `IVM_LVL_NMI;
    end
    else if (hard_fault_i)
    begin
      next_num = `IVM_EXC_FAULT;
      next_lvl = `IVM_LVL_FAULT;
    end
    else if (arb_valid)
    begin
      // peripheral numbers sit past core exceptions
      next_num = arb_idx + `IVM_NUM_CORE_EXC;
      next_lvl = arb_lvl;
    end
    // nest only on a strictly more urgent level
    next_req = (next_lvl < top_lvl);
  end

  // Pending flags: a new request wins over the clear of an accepted entry
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pending_o <= {NIRQ{1'b0}};
      nmi_pend  <= 1'b0;
      nmi_prev  <= 1'b0;
      rst_pend  <= 1'b1;
    end
    else
    begin
      nmi_prev <= nmi_i;
      // Acknowledge clears only the entry shown to the core
      if (taken && exc_num_o >= `IVM_NUM_CORE_EXC)
        pending_o <= (pending_o & ~({{(NIRQ-1){1'b0}}, 1'b1}
                     << (exc_num_o - `IVM_NUM_CORE_EXC))) | req_map;
      else
        pending_o <= pending_o | req_map;
      // NMI latches on its rising edge so a long pulse enters once
      if (nmi_i && !nmi_prev)
        nmi_pend <= 1'b1;
      else if (taken && exc_num_o == `IVM_EXC_NMI)
        nmi_pend <= 1'b0;
      if (taken && exc_num_o == `IVM_EXC_RESET)
        rst_pend <= 1'b0;
    end
  end

  // Nesting stack: push on entry while below DEPTH, pop on return; an entry and a
  // return in the same cycle push the entry and drop the return unless the stack is full
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sp <= 5'h00;
      for (j = 0; j < DEPTH; j = j + 1)
        stk[j] <= `IVM_LVL_IDLE;
    end
    else if (taken && sp < DEPTH)
    begin
      stk[sp] <= exc_level_o;
      sp      <= sp + 5'h01;
    end
    else if (exc_return_i && sp != 5'h00)
    begin
      sp <= sp - 5'h01;
    end
  end

  // Presented request; dropped for one cycle after acceptance so the
  // next choice sees the updated pending flags and stack
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      exc_req_o      <= 1'b0;
      exc_num_o      <= {`IVM_EXC_W{1'b0}};
      exc_vec_addr_o <= 32'h0000_0000;
      exc_level_o    <= `IVM_LVL_IDLE;
    end
    else
    begin
      exc_req_o      <= next_req & ~taken;
      exc_num_o      <= next_num;
      exc_vec_addr_o <= vec_addr(next_num);
      exc_level_o    <= next_lvl;
    end
  end

endmodule

// File: common/ivm_defs.vh
// Shared constants for the interrupt vector mapper
`ifndef IVM_DEFS_VH
`define IVM_DEFS_VH

// Channel counts and widths
`define IVM_NUM_IRQ       65
`define IVM_NUM_CORE_EXC  7'h10
`define IVM_PRIO_W        4
`define IVM_EXC_W         7
`define IVM_LVL_W         5

// Level codes: fixed priority -3 maps to code 0, programmable p to p + 3
`define IVM_LVL_RESET     5'h00
`define IVM_LVL_NMI       5'h01
`define IVM_LVL_FAULT     5'h02
`define IVM_LVL_PROG_OFS  5'h03
`define IVM_LVL_IDLE      5'h1F

// Core exception numbers
`define IVM_EXC_RESET     7'h01
`define IVM_EXC_NMI       7'h02
`define IVM_EXC_FAULT     7'h03

// Peripheral vector numbers
`define IVM_VEC_TAMPER    2
`define IVM_VEC_EXT0      6
`define IVM_VEC_DMA_A     11
`define IVM_VEC_ADC       18
`define IVM_VEC_USB_HI    19
`define IVM_VEC_USB_LO    20
`define IVM_VEC_CAN_RX1   21
`define IVM_VEC_EXT5_9    23
`define IVM_VEC_TMR_A     24
`define IVM_VEC_EXT10_15  40
`define IVM_VEC_TMR_B     43

// Source group sizes
`define IVM_N_EXT         16
`define IVM_N_EXT_OWN     5
`define IVM_EXT_MID_HI    9     // Top line of the shared 5-9 group
`define IVM_EXT_HI_LO     10    // Bottom line of the shared 10-15 group
`define IVM_N_DMA_A       7
`define IVM_N_TMR_A       4
`define IVM_N_TMR_B       3

// Vector table byte address is exception number shifted left by this amount (times four)
`define IVM_VT_SHIFT      2

`endif

// File: core/ivm_prio_arb.v
// Priority arbiter: picks the most urgent pending enabled peripheral request
`timescale 1ns/1ns
`include "ivm_defs.vh"

module ivm_prio_arb #(
  parameter N = `IVM_NUM_IRQ
) (
  // Requests and their priority fields
  input  wire [N-1:0]             req_i,
  input  wire [N*`IVM_PRIO_W-1:0] prio_i,
  // Winner
  output reg                      valid_o,
  output reg  [`IVM_EXC_W-1:0]    idx_o,
  output reg  [`IVM_LVL_W-1:0]    lvl_o
);

  integer               i;      // Channel walk
  reg [`IVM_LVL_W-1:0]  lvl;    // Level code of channel i

  // Linear scan; strict compare lets the lower vector number win a tie
  // level arbitration
  always @*
  begin
    valid_o = 1'b0;
    idx_o   = {`IVM_EXC_W{1'b0}};
    lvl_o   = `IVM_LVL_IDLE;
    lvl     = `IVM_LVL_IDLE;
    for (i = 0; i < N; i = i + 1)
    begin
      // programmable levels start below fixed ones
      lvl = {1'b0, prio_i[i*`IVM_PRIO_W +: `IVM_PRIO_W]} + `IVM_LVL_PROG_OFS;
      if (req_i[i] && (lvl < lvl_o))
      begin
        valid_o = 1'b1;
        idx_o   = i[`IVM_EXC_W-1:0];
        lvl_o   = lvl;
      end
    end
  end

endmodule

// File: tb/ivm_checker.sv
// Checker: mapping and entry handshake properties at the mapper's ports
`timescale 1ns/1ns
`include "ivm_defs.vh"
module ivm_checker #(
  parameter NIRQ = `IVM_NUM_IRQ
) (
  // Clock and reset
  input wire                        mclk_i,
  input wire                        rst_i,
  // Watched sources
  input wire [`IVM_N_EXT-1:0]       ext_line_irq_i,
  input wire [`IVM_N_DMA_A-1:0]     dma_a_channel_irq_i,
  input wire                        tamper_irq_i,
  input wire [`IVM_N_TMR_B-1:0]     adv_timer_b_irq_i,
  input wire [NIRQ*`IVM_PRIO_W-1:0] irq_prio_i,
  // Entry side
  input wire                        exc_ack_i,
  input wire                        exc_req_o,
  input wire [`IVM_EXC_W-1:0]       exc_num_o,
  input wire [31:0]                 exc_vec_addr_o,
  input wire [`IVM_LVL_W-1:0]       exc_level_o,
  input wire [NIRQ-1:0]             pending_o,
  input wire [`IVM_LVL_W-1:0]       active_level_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  reset_entry_a: assert property (
    $past(rst_i) |=> exc_req_o && exc_num_o == `IVM_EXC_RESET)
    else $error("reset entry not offered first");
  vec_addr_a: assert property (
    exc_req_o |-> exc_vec_addr_o == {23'h0, exc_num_o, 2'b00})
    else $error("vector address not four times number");
  fixed_lvl_a: assert property (
    exc_req_o && exc_num_o < `IVM_NUM_CORE_EXC |-> exc_level_o == exc_num_o[4:0] - 5'h01)
    else $error("fixed level wrong");
  prio_lvl_a: assert property (
    exc_req_o && exc_num_o >= `IVM_NUM_CORE_EXC && $stable(irq_prio_i) |-> exc_level_o ==
    irq_prio_i[(exc_num_o - `IVM_NUM_CORE_EXC) * 4 +: 4] + `IVM_LVL_PROG_OFS)
    else $error("programmed level wrong");
  strict_urg_a: assert property (
    exc_req_o |-> exc_level_o < active_level_o)
    else $error("offer not more urgent than active");
  ack_drop_a: assert property (
    exc_req_o && exc_ack_i |=> !exc_req_o)
    else $error("offer held after ack");
  tamper_pend_a: assert property (
    tamper_irq_i |=> pending_o[`IVM_VEC_TAMPER])
    else $error("tamper not pending");
  dma_pend_a: assert property (
    dma_a_channel_irq_i[6] |=> pending_o[17])
    else $error("dma channel 7 not pending");
  tmrb_pend_a: assert property (
    adv_timer_b_irq_i[2] |=> pending_o[45])
    else $error("timer b third request not pending");
  ext_merge_a: assert property (
    ext_line_irq_i[12] [*6] |=> pending_o[`IVM_VEC_EXT10_15])
    else $error("merged pin lines not pending");
endmodule
bind ivm_top ivm_checker #(.NIRQ(NIRQ)) u_ivm_checker (.mclk_i(mclk_i), .rst_i(rst_i),
  .ext_line_irq_i(ext_line_irq_i), .dma_a_channel_irq_i(dma_a_channel_irq_i),
  .tamper_irq_i(tamper_irq_i), .adv_timer_b_irq_i(adv_timer_b_irq_i),
  .irq_prio_i(irq_prio_i), .exc_ack_i(exc_ack_i), .exc_req_o(exc_req_o),
  .exc_num_o(exc_num_o), .exc_vec_addr_o(exc_vec_addr_o), .exc_level_o(exc_level_o),
  .pending_o(pending_o), .active_level_o(active_level_o));

// File: tb/ivm_core_model.sv
// Core model: takes offers after a set wait, returns after a set hold
`timescale 1ns/1ns
module ivm_core_model (
  // Clock and reset
  input  wire       mclk_i,
  input  wire       rst_i,
  // Pace from the bench
  input  wire [3:0] wait_i,
  input  wire [7:0] hold_i,
  // Entry handshake
  input  wire       req_i,
  output reg        ack_o,
  output reg        ret_o
);
  reg [3:0] dly;   // Cycles spent on this offer
  reg [7:0] run;   // Cycles left in the handler
  reg [4:0] nest;  // Entered, not yet returned
  // Never acks on the cycle after an ack, as the offer is down then
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      ret_o <= 1'b0;
      dly <= 4'h0;
      run <= 8'h0;
      nest <= 5'h0;
    end
    else
    begin
      ack_o <= req_i && !ack_o && dly >= wait_i;
      dly <= (req_i && !ack_o && dly < wait_i) ? dly + 4'h1 : 4'h0;
      ret_o <= !ack_o && nest != 5'h0 && run == 8'h0;
      if (ack_o)
        nest <= nest + 5'h1;
      else if (nest != 5'h0 && run == 8'h0)
        nest <= nest - 5'h1;
      // A preempting entry restarts the handler time
      run <= (ack_o || run == 8'h0) ? hold_i : run - 8'h1;
    end
  end
endmodule

// File: tb/ivm_top_tb_top.sv
// Bench: drives every source, paces the core model, checks each entry
`timescale 1ns/1ns
`include "ivm_defs.vh"
module ivm_top_tb_top;
  reg          mclk_i = 1'b0;
  reg          rst_i = 1'b1;
  reg  [39:0]  src = 40'h0;           // One bit per source
  reg          nmi = 1'b0;
  reg          fault = 1'b0;
  reg  [64:0]  en = {65{1'b1}};       // Channel enables
  reg  [259:0] prio = 260'h0;         // Priority fields
  reg  [3:0]   wait_c = 4'h0;         // Core ack delay
  reg  [7:0]   hold_c = 8'h4;         // Handler length
  reg  [31:0]  seed = 32'h16;
  reg  [6:0]   e;
  reg  [6:0]   exp_q[$];              // Expected numbers, oldest first
  integer      error_cnt = 0;
  integer      n_compared = 0;
  integer      k;
  wire         ack, ret, req;
  wire [6:0]   num;
  wire [31:0]  addr;
  wire [4:0]   lvl, act;
  wire [64:0]  pend;
  always #4 mclk_i = ~mclk_i;
  ivm_top u_ivm_top (.mclk_i(mclk_i), .rst_i(rst_i),
    .periph_irq_i({src[39], 33'h0, src[38], 30'h0}), .ext_line_irq_i(src[15:0]),
    .dma_a_channel_irq_i(src[22:16]), .usb_hipri_irq_i(src[23]), .can_a_tx_irq_i(src[24]),
    .usb_lopri_irq_i(src[25]), .can_a_rx0_irq_i(src[26]), .can_a_rx1_irq_i(src[27]),
    .adc_a_irq_i(src[28]), .adc_b_irq_i(src[29]), .tamper_irq_i(src[30]),
    .adv_timer_a_irq_i(src[34:31]), .adv_timer_b_irq_i(src[37:35]), .nmi_i(nmi),
    .hard_fault_i(fault), .irq_enable_i(en), .irq_prio_i(prio), .exc_ack_i(ack),
    .exc_return_i(ret), .exc_req_o(req), .exc_num_o(num), .exc_vec_addr_o(addr),
    .exc_level_o(lvl), .pending_o(pend), .active_level_o(act));
  ivm_core_model u_ivm_core_model (.mclk_i(mclk_i), .rst_i(rst_i), .wait_i(wait_c),
    .hold_i(hold_c), .req_i(req), .ack_o(ack), .ret_o(ret));
  function automatic [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  // Vector number of each source bit
  function automatic [6:0] vec_of(input integer s);
    if (s < 5) vec_of = 6 + s;
    else if (s < 10) vec_of = 23;
    else if (s < 16) vec_of = 40;
    else if (s < 23) vec_of = s - 5;
    else if (s < 25) vec_of = 19;
    else if (s < 27) vec_of = 20;
    else if (s == 27) vec_of = 21;
    else if (s < 30) vec_of = 18;
    else if (s == 30) vec_of = 2;
    else if (s < 35) vec_of = s - 7;
    else if (s < 38) vec_of = s + 8;
    else vec_of = (s == 38) ? 30 : 64;
  endfunction
  // Level code an entry must carry: fixed -3..-1 as 0..2, programmed p as p + 3
  function automatic [4:0] exp_lvl(input [6:0] n);
    if (n < 7'h10) exp_lvl = n[4:0] - 5'h01;
    else exp_lvl = {1'b0, prio[4*(n - 7'h10) +: 4]} + 5'h03;
  endfunction
  task miss(input [63:0] what, input [31:0] ex, input [31:0] got);
    error_cnt = error_cnt + 1;
    $display("MISMATCH %0s expected %0h seen %0h", what, ex, got);
  endtask
  task close_out;
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Bounded wait until at most the given count of entries is owed
  task wait_q(input integer left, input integer idle);
    integer n;
    n = 0;
    while ((exp_q.size() > left || (idle && (act !== 5'h1F || req !== 1'b0))) && n < 400)
    begin
      @(posedge mclk_i);
      n = n + 1;
    end
    if (n == 400) miss("wait", left, exp_q.size());
  endtask
  // Source pends while masked; unmasking then yields exactly one entry
  task fire(input integer s);
    integer i;
    reg [6:0] v;
    v = vec_of(s);
    for (i = 0; i < 65; i = i + 1)
    begin
      seed = xs(seed);
      prio[4*i +: 4] <= seed[3:0];
    end
    wait_c <= seed[7:4];
    hold_c <= {4'h0, seed[11:8]};
    en[v] <= 1'b0;
    src[s] <= 1'b1;
    i = 0;
    while (pend[v] !== 1'b1 && i < 20)
    begin
      @(posedge mclk_i);
      i = i + 1;
    end
    if (i == 20) miss("pending", 1, 0);
    repeat (2) @(posedge mclk_i);
    src[s] <= 1'b0;
    repeat (6) @(posedge mclk_i);
    exp_q.push_back(7'h10 + v);
    en[v] <= 1'b1;
    wait_q(0, 1);
  endtask
  task pulse(input integer s);
    exp_q.push_back(7'h10 + vec_of(s));
    src[s] <= 1'b1;
    @(posedge mclk_i);
    src[s] <= 1'b0;
  endtask
  // Monitor: each taken entry against the oldest expectation
  always @(posedge mclk_i)
  begin
    if (rst_i === 1'b0 && req === 1'b1 && ack === 1'b1)
    begin
      n_compared = n_compared + 1;
      e = (exp_q.size() == 0) ? 7'h7F : exp_q.pop_front();
      if (num !== e) miss("exc_num", e, num);
      if (addr !== {23'h0, e, 2'b00}) miss("vec_addr", {e, 2'b00}, addr);
      if (lvl !== exp_lvl(e)) miss("exc_level", exp_lvl(e), lvl);
    end
  end
  initial
  begin
    #240000;
    error_cnt = error_cnt + 1;
    close_out;
  end
  initial
  begin
    exp_q.push_back(`IVM_EXC_RESET);
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    wait_q(0, 1);
    for (k = 0; k < 40; k = k + 1) fire(k);
    // Preempt, then a less urgent request refused until both return
    prio[256 +: 4] <= 4'h9;
    prio[120 +: 4] <= 4'h1;
    hold_c <= 8'h28;
    wait_c <= 4'h0;
    pulse(39);
    wait_q(0, 0);
    pulse(38);
    wait_q(0, 0);
    pulse(39);
    wait_q(0, 1);
    // Fixed order: NMI, then held fault, then the peripheral
    hold_c <= 8'h06;
    exp_q.push_back(`IVM_EXC_NMI);
    exp_q.push_back(`IVM_EXC_FAULT);
    nmi <= 1'b1;
    fault <= 1'b1;
    pulse(39);
    nmi <= 1'b0;
    wait_q(1, 0);
    fault <= 1'b0;
    wait_q(0, 1);
    // Second reset in mid-run
    rst_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    exp_q.delete();
    exp_q.push_back(`IVM_EXC_RESET);
    rst_i <= 1'b0;
    wait_q(0, 1);
    close_out;
  end
endmodule
